//--- iacarh_pkg.sv
// Functional notes
// - ack payload: byte0 message code, byte1 subcode, bytes2-3 tag, byte4 return code
// - return code 00h success, 01h task not found, 04h overlapped messages
// - return code 20h no allegiance condition, FFh invalid field, others reserved
// - an ack is also accepted as the answer to a faulty command
// - a link reset leaves every protocol construct untouched
// - absolute or power-on reset reinitialises and clears all constructs
// - total or local reset clears everything and restores saved conditions
// - every frame is tagged; untagged queue type never goes out
// - untagged emulation: one command per unit, reused tag, simple queue
// - normal allegiance bit clear means emulate classic contingent allegiance
// - check condition status copies destination and unit from table into entry, holds queue
// - allegiance-active status requeues the command in its original order
// - command to held destination and unit goes out with allegiance queue type
// - while an entry exists, further command requests are held; one allegiance-typed command to the held unit is still admitted
// - status for recorded tag sends clear request; its ack empties entry
// - entry holds tag, eight-byte destination id and logical unit
// - per-command confirm bit enables confirmed status for that command only
// - the ack answers every task management request
// - clear request carries code, subcode 34h, tag, reply path id and unit
package iacarh_pkg;
	localparam logic [7:0]  MSG_CODE        = 8'h83;
	localparam logic [7:0]  SUB_ACK         = 8'h03;
	localparam logic [7:0]  SUB_CLEAR       = 8'h34;
	localparam logic [7:0]  RC_OK           = 8'h00;
	localparam logic [7:0]  RC_NO_TASK      = 8'h01;
	localparam logic [7:0]  RC_OVERLAP      = 8'h04;
	localparam logic [7:0]  RC_NO_ACA       = 8'h20;
	localparam logic [7:0]  RC_INVALID      = 8'hff;
	// scsi status values seen in status messages
	localparam logic [7:0]  STAT_CHECK      = 8'h02;
	localparam logic [7:0]  STAT_ACA_ACTIVE = 8'h30;
	// outstanding command table geometry
	localparam int          TBL_AW          = 3;
	localparam int          TBL_DEPTH       = 8;
	// tags the block owns itself
	localparam logic [7:0]  UNTAG_TAG_HI    = 8'hff;
	localparam logic [15:0] CLEAR_TAG       = 16'hfff0;
	// register map
	localparam int          REG_AW          = 8;
	localparam logic [7:0]  REG_PATH        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_ENTRY       = 8'h08;
	localparam int          ST_HOLD_BIT     = 0;
	localparam int          ST_ERR_BIT      = 1;
	localparam int          ST_RC_LSB       = 8;
	localparam logic [31:0] PATH_RST        = 32'h0000_0000;

	typedef enum logic [2:0] {
		Q_UNTAGGED,
		Q_SIMPLE,
		Q_ORDERED,
		Q_HEAD,
		Q_ACA
	} iacarh_queue_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOOKUP,
		ST_CLR_SEND,
		ST_CLR_WAIT
	} iacarh_state_type;

	// command request from the application client
	typedef struct packed {
		logic [15:0]      tag;
		logic [63:0]      dest_id;
		logic [7:0]       lun;
		iacarh_queue_type queue;
		logic             normal_allegiance_bit;
		logic             confirm;
	} iacarh_cmd_type;

	// outgoing link_message: command or clear request
	typedef struct packed {
		logic             is_clear;
		logic [15:0]      tag;
		logic [63:0]      dest_id;
		logic [7:0]       lun;
		iacarh_queue_type queue_type_field;
		logic             confirm;
		logic [31:0]      reply_path_id;
	} iacarh_tx_type;

	// incoming link_message: status or acknowledgement payload
	typedef struct packed {
		logic             is_status;
		logic [15:0]      tag;
		logic [7:0]       status;
		logic [4:0][7:0]  ack_bytes;
	} iacarh_rx_type;

	// decoded acknowledgement
	typedef struct packed {
		logic [15:0] tag;
		logic [7:0]  code;
		logic        ok;
		logic        task_not_found;
		logic        overlapped;
		logic        no_aca;
		logic        invalid;
		logic        reserved;
	} iacarh_ack_type;

	// stored per outstanding command
	typedef struct packed {
		logic [63:0] dest_id;
		logic [7:0]  lun;
		logic        normal_allegiance_bit;
	} iacarh_entry_type;
endpackage : iacarh_pkg

//--- iacarh_table_mem.sv
`timescale 1ns/1ps
`default_nettype none
module iacarh_table_mem (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_reset,
	input  wire logic                          i_we,
	input  wire logic [iacarh_pkg::TBL_AW-1:0] i_waddr,
	input  wire iacarh_pkg::iacarh_entry_type  i_wdata,
	input  wire logic [iacarh_pkg::TBL_AW-1:0] i_raddr,
	output var  iacarh_pkg::iacarh_entry_type  o_rdata
);
	import iacarh_pkg::*;

	iacarh_entry_type mem_r [TBL_DEPTH];
	iacarh_entry_type rdata_r;

	// storage array, data only, validity lives with the caller
	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem_r[i_waddr] <= i_wdata;
		end
	end

	// registered read port
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= mem_r[i_raddr];
		end
	end

	assign o_rdata = rdata_r;
endmodule : iacarh_table_mem
`default_nettype wire

//--- iacarh_handler.sv
`timescale 1ns/1ps
`default_nettype none
module iacarh_handler (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_reset,
	input  wire logic                          i_link_reset,
	input  wire logic                          i_hard_reset,
	input  wire logic                          i_local_reset,
	input  wire logic                          i_cmd_valid,
	input  wire iacarh_pkg::iacarh_cmd_type    i_cmd,
	output logic                               o_cmd_ready,
	output logic                               o_tx_valid,
	output var  iacarh_pkg::iacarh_tx_type     o_tx,
	input  wire logic                          i_tx_ready,
	input  wire logic                          i_rx_valid,
	input  wire iacarh_pkg::iacarh_rx_type     i_rx,
	output logic                               o_rx_ready,
	output logic                               o_ack_valid,
	output var  iacarh_pkg::iacarh_ack_type    o_ack,
	output logic                               o_requeue_valid,
	output logic [15:0]                        o_requeue_tag,
	output logic                               o_queue_hold,
	output logic                               o_proto_err,
	output logic                               o_restore_saved,
	input  wire logic [iacarh_pkg::REG_AW-1:0] i_reg_addr,
	input  wire logic [31:0]                   i_reg_wdata,
	input  wire logic                          i_reg_wr,
	input  wire logic                          i_reg_rd,
	output logic [31:0]                        o_reg_rdata
);
	import iacarh_pkg::*;

	function automatic logic rc_reserved(input logic [7:0] code);
		rc_reserved = !(code == RC_OK || code == RC_NO_TASK ||
			code == RC_OVERLAP || code == RC_NO_ACA || code == RC_INVALID);
	endfunction : rc_reserved

	iacarh_state_type       state_r,       state_nxt;
	logic                   ent_valid_r,   ent_valid_nxt;
	logic                   ent_aca_r,     ent_aca_nxt;
	logic [15:0]            ent_tag_r,     ent_tag_nxt;
	logic [63:0]            ent_dest_r,    ent_dest_nxt;
	logic [7:0]             ent_lun_r,     ent_lun_nxt;
	logic [TBL_DEPTH-1:0]   busy_r,        busy_nxt;
	logic [TBL_DEPTH-1:0]   busy_set,      busy_clr;
	logic                   tx_valid_r,    tx_valid_nxt;
	iacarh_tx_type          tx_r,          tx_nxt;
	logic [15:0]            st_tag_r,      st_tag_nxt;
	logic [7:0]             st_val_r,      st_val_nxt;
	logic                   ack_valid_r,   ack_valid_nxt;
	iacarh_ack_type         ack_r,         ack_nxt;
	logic                   rq_valid_r,    rq_valid_nxt;
	logic [15:0]            rq_tag_r,      rq_tag_nxt;
	logic                   restore_r,     restore_nxt;
	logic                   err_r,         err_nxt;
	logic                   err_set;
	logic [7:0]             last_rc_r,     last_rc_nxt;
	logic [31:0]            path_r,        path_nxt;
	logic [31:0]            rdata_r,       rdata_nxt;
	logic                   mem_we;
	iacarh_entry_type       mem_wdata;
	iacarh_entry_type       mem_rd;
	logic [TBL_AW-1:0]      mem_raddr;
	logic [15:0]            eff_tag;
	iacarh_queue_type       eff_queue;
	logic [TBL_AW-1:0]      cmd_idx;
	logic                   hits_entry;
	logic                   cmd_fire;
	logic                   rx_fire;
	logic                   clr;
	logic [15:0]            ack_tag;
	logic [TBL_AW-1:0]      ack_idx;
	logic [TBL_AW-1:0]      st_idx;

	// untagged requests reuse one tag per unit and go out as simple
	always_comb begin
		if (i_cmd.queue == Q_UNTAGGED) begin
			eff_tag   = {UNTAG_TAG_HI, i_cmd.lun};
			eff_queue = Q_SIMPLE;
		end else begin
			eff_tag   = i_cmd.tag;
			eff_queue = i_cmd.queue;
		end
	end

	assign cmd_idx    = eff_tag[TBL_AW-1:0];
	assign hits_entry = ent_valid_r && (i_cmd.dest_id == ent_dest_r) &&
		(i_cmd.lun == ent_lun_r);
	// a held queue admits just one allegiance-typed command
	assign o_cmd_ready = (state_r == ST_IDLE) && !tx_valid_r &&
		!busy_r[cmd_idx] && (!ent_valid_r || (hits_entry && !ent_aca_r));
	assign o_rx_ready = (state_r == ST_IDLE) ||
		((state_r == ST_CLR_WAIT) && !i_rx.is_status);
	assign cmd_fire  = i_cmd_valid && o_cmd_ready;
	assign rx_fire   = i_rx_valid && o_rx_ready;
	// link reset is deliberately absent here
	assign clr       = i_hard_reset || i_local_reset;
	assign ack_tag   = {i_rx.ack_bytes[2], i_rx.ack_bytes[3]};
	assign ack_idx   = ack_tag[TBL_AW-1:0];
	assign st_idx    = st_tag_r[TBL_AW-1:0];
	assign mem_raddr = i_rx.tag[TBL_AW-1:0];
	assign mem_wdata = '{dest_id: i_cmd.dest_id, lun: i_cmd.lun,
		normal_allegiance_bit: i_cmd.normal_allegiance_bit};

	// outstanding table slot flags, set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < TBL_DEPTH; gi++) begin : g_busy
			assign busy_nxt[gi] = clr ? 1'b0 :
				(busy_set[gi] | (busy_r[gi] & ~busy_clr[gi]));
		end
	endgenerate

	iacarh_table_mem u_table (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_we      (mem_we),
		.i_waddr   (cmd_idx),
		.i_wdata   (mem_wdata),
		.i_raddr   (mem_raddr),
		.o_rdata   (mem_rd)
	);

	// protocol sequencing: commands, status, clear exchange, acks
	always_comb begin
		state_nxt     = state_r;
		ent_valid_nxt = ent_valid_r;
		ent_aca_nxt   = ent_aca_r;
		ent_tag_nxt   = ent_tag_r;
		ent_dest_nxt  = ent_dest_r;
		ent_lun_nxt   = ent_lun_r;
		busy_set      = '0;
		busy_clr      = '0;
		tx_valid_nxt  = tx_valid_r && !i_tx_ready;
		tx_nxt        = tx_r;
		st_tag_nxt    = st_tag_r;
		st_val_nxt    = st_val_r;
		ack_valid_nxt = 1'b0;
		ack_nxt       = ack_r;
		rq_valid_nxt  = 1'b0;
		rq_tag_nxt    = rq_tag_r;
		restore_nxt   = 1'b0;
		err_set       = 1'b0;
		last_rc_nxt   = last_rc_r;
		mem_we        = 1'b0;
		if (cmd_fire) begin
			tx_valid_nxt = 1'b1;
			tx_nxt = '{is_clear: 1'b0, tag: eff_tag, dest_id: i_cmd.dest_id,
				lun: i_cmd.lun,
				queue_type_field: ent_valid_r ? Q_ACA : eff_queue,
				confirm: i_cmd.confirm,
				reply_path_id: path_r};
			busy_set[cmd_idx] = 1'b1;
			mem_we = 1'b1;
			if (ent_valid_r) begin
				ent_aca_nxt = 1'b1;
				ent_tag_nxt = eff_tag;
			end
		end
		case (state_r)
			ST_IDLE: begin
				if (rx_fire && i_rx.is_status) begin
					st_tag_nxt = i_rx.tag;
					st_val_nxt = i_rx.status;
					state_nxt  = ST_LOOKUP;
				end
			end
			ST_LOOKUP: begin
				state_nxt = ST_IDLE;
				busy_clr[st_idx] = 1'b1;
				if (!busy_r[st_idx]) begin
					err_set = 1'b1;
				end else if (st_val_r == STAT_ACA_ACTIVE) begin
					rq_valid_nxt = 1'b1;
					rq_tag_nxt   = st_tag_r;
				end else if (ent_valid_r && ent_aca_r &&
					st_tag_r == ent_tag_r) begin
					state_nxt = ST_CLR_SEND;
				end else if (st_val_r == STAT_CHECK && !ent_valid_r &&
					!mem_rd.normal_allegiance_bit) begin
					ent_valid_nxt = 1'b1;
					ent_aca_nxt   = 1'b0;
					ent_dest_nxt  = mem_rd.dest_id;
					ent_lun_nxt   = mem_rd.lun;
				end
			end
			ST_CLR_SEND: begin
				if (!tx_valid_r) begin
					tx_valid_nxt = 1'b1;
					tx_nxt = '{is_clear: 1'b1, tag: CLEAR_TAG,
						dest_id: ent_dest_r, lun: ent_lun_r,
						queue_type_field: Q_SIMPLE, confirm: 1'b0,
						reply_path_id: path_r};
					state_nxt = ST_CLR_WAIT;
				end
			end
			default: begin
			end
		endcase
		// acknowledgement decode, also answers to faulty commands
		if (rx_fire && !i_rx.is_status) begin
			if (i_rx.ack_bytes[0] != MSG_CODE ||
				i_rx.ack_bytes[1] != SUB_ACK) begin
				err_set = 1'b1;
			end else begin
				ack_valid_nxt = 1'b1;
				ack_nxt = '{tag: ack_tag, code: i_rx.ack_bytes[4],
					ok: i_rx.ack_bytes[4] == RC_OK,
					task_not_found: i_rx.ack_bytes[4] == RC_NO_TASK,
					overlapped: i_rx.ack_bytes[4] == RC_OVERLAP,
					no_aca: i_rx.ack_bytes[4] == RC_NO_ACA,
					invalid: i_rx.ack_bytes[4] == RC_INVALID,
					reserved: rc_reserved(i_rx.ack_bytes[4])};
				last_rc_nxt = i_rx.ack_bytes[4];
				if (rc_reserved(i_rx.ack_bytes[4])) begin
					err_set = 1'b1;
				end else if (state_r == ST_CLR_WAIT &&
					ack_tag == CLEAR_TAG) begin
					ent_valid_nxt = 1'b0;
					ent_aca_nxt   = 1'b0;
					state_nxt     = ST_IDLE;
				end else if (busy_r[ack_idx]) begin
					busy_clr[ack_idx] = 1'b1;
				end else begin
					err_set = 1'b1;
				end
			end
		end
		if (clr) begin
			state_nxt     = ST_IDLE;
			ent_valid_nxt = 1'b0;
			ent_aca_nxt   = 1'b0;
			tx_valid_nxt  = 1'b0;
			rq_valid_nxt  = 1'b0;
			restore_nxt   = i_local_reset;
		end
	end

	// register the sequencing state
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_r     <= ST_IDLE;
			ent_valid_r <= 1'b0;
			ent_aca_r   <= 1'b0;
			ent_tag_r   <= '0;
			ent_dest_r  <= '0;
			ent_lun_r   <= '0;
			busy_r      <= '0;
			tx_valid_r  <= 1'b0;
			tx_r        <= '0;
			st_tag_r    <= '0;
			st_val_r    <= '0;
			ack_valid_r <= 1'b0;
			ack_r       <= '0;
			rq_valid_r  <= 1'b0;
			rq_tag_r    <= '0;
			restore_r   <= 1'b0;
			last_rc_r   <= '0;
		end else begin
			state_r     <= state_nxt;
			ent_valid_r <= ent_valid_nxt;
			ent_aca_r   <= ent_aca_nxt;
			ent_tag_r   <= ent_tag_nxt;
			ent_dest_r  <= ent_dest_nxt;
			ent_lun_r   <= ent_lun_nxt;
			busy_r      <= busy_nxt;
			tx_valid_r  <= tx_valid_nxt;
			tx_r        <= tx_nxt;
			st_tag_r    <= st_tag_nxt;
			st_val_r    <= st_val_nxt;
			ack_valid_r <= ack_valid_nxt;
			ack_r       <= ack_nxt;
			rq_valid_r  <= rq_valid_nxt;
			rq_tag_r    <= rq_tag_nxt;
			restore_r   <= restore_nxt;
			last_rc_r   <= last_rc_nxt;
		end
	end

	// software registers: reply path, sticky error, read mux
	always_comb begin
		path_nxt = path_r;
		err_nxt  = err_r;
		rdata_nxt = '0;
		if (i_reg_wr && i_reg_addr == REG_PATH) begin
			path_nxt = i_reg_wdata;
		end
		if (i_reg_wr && i_reg_addr == REG_STATUS && i_reg_wdata[ST_ERR_BIT]) begin
			err_nxt = 1'b0;
		end
		if (err_set) begin
			err_nxt = 1'b1; // set beats clear
		end
		if (i_reg_rd) begin
			if (i_reg_addr == REG_PATH) begin
				rdata_nxt = path_r;
			end else if (i_reg_addr == REG_STATUS) begin
				rdata_nxt[ST_HOLD_BIT] = ent_valid_r;
				rdata_nxt[ST_ERR_BIT]  = err_r;
				rdata_nxt[ST_RC_LSB+7:ST_RC_LSB] = last_rc_r;
			end else if (i_reg_addr == REG_ENTRY) begin
				rdata_nxt = {ent_valid_r, ent_aca_r, 6'h00, ent_lun_r, ent_tag_r};
			end else begin
				rdata_nxt = '0;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			path_r  <= PATH_RST;
			err_r   <= 1'b0;
			rdata_r <= '0;
		end else begin
			path_r  <= path_nxt;
			err_r   <= err_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// outputs
	assign o_tx_valid      = tx_valid_r;
	assign o_tx            = tx_r;
	assign o_ack_valid     = ack_valid_r;
	assign o_ack           = ack_r;
	assign o_requeue_valid = rq_valid_r;
	assign o_requeue_tag   = rq_tag_r;
	assign o_queue_hold    = ent_valid_r;
	assign o_proto_err     = err_r;
	assign o_restore_saved = restore_r;
	assign o_reg_rdata     = rdata_r;

	// checks
	sequence seq_status_in(logic [7:0] sv);
		rx_fire && i_rx.is_status && i_rx.status == sv &&
			busy_r[i_rx.tag[TBL_AW-1:0]];
	endsequence
	sequence seq_check_lookup;
		seq_status_in(STAT_CHECK) ##0 !ent_valid_r
			##1 (state_r == ST_LOOKUP && !mem_rd.normal_allegiance_bit);
	endsequence

	AST_HOLD_BLOCKS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(ent_valid_r && !(hits_entry && !ent_aca_r)) |-> !o_cmd_ready)
		else $error("command accepted while allegiance entry held");
	AST_ACA_QUEUE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(cmd_fire && ent_valid_r && !clr) |=> (o_tx_valid &&
			o_tx.queue_type_field == Q_ACA && ent_tag_r == o_tx.tag))
		else $error("held command not sent with allegiance queue type");
	AST_NO_UNTAGGED: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_tx_valid |-> o_tx.queue_type_field != Q_UNTAGGED)
		else $error("untagged queue type sent");
	AST_CLEAR_MSG: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(o_tx_valid && o_tx.is_clear) |-> (o_tx.tag == CLEAR_TAG &&
			o_tx.lun == ent_lun_r && state_r == ST_CLR_WAIT))
		else $error("clear request malformed");
	AST_HARD_RESET: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_hard_reset |=> (!o_queue_hold && !o_tx_valid && busy_r == '0))
		else $error("hard reset left constructs");
	AST_LINK_RESET: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(i_link_reset && !clr && !i_cmd_valid && !i_rx_valid &&
			state_r == ST_IDLE) |=> ($stable(o_queue_hold) && $stable(busy_r)))
		else $error("link reset disturbed constructs");
	AST_LOCAL_RESTORE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		i_local_reset |=> (o_restore_saved && !o_queue_hold) ##1 !o_restore_saved)
		else $error("local reset did not restore");
	AST_RESERVED_ERR: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(rx_fire && !i_rx.is_status && !clr && i_rx.ack_bytes[0] == MSG_CODE &&
			i_rx.ack_bytes[1] == SUB_ACK && rc_reserved(i_rx.ack_bytes[4]))
			|=> (o_proto_err && o_ack.reserved && $stable(o_queue_hold)))
		else $error("reserved return code not flagged");
	AST_ACK_DECODE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		o_ack_valid |-> (o_ack.ok == (o_ack.code == RC_OK) &&
			o_ack.no_aca == (o_ack.code == RC_NO_ACA)))
		else $error("return code decoded wrongly");
	AST_CHECK_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(seq_check_lookup ##0 !clr) |=> o_queue_hold)
		else $error("check condition did not hold queue");
	AST_REQUEUE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
		(seq_status_in(STAT_ACA_ACTIVE) ##1 !clr) |=>
			(o_requeue_valid && o_requeue_tag == $past(st_tag_r)))
		else $error("allegiance-active status not requeued");
endmodule : iacarh_handler
`default_nettype wire

//--- iacarh_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module iacarh_target_model (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_reset,
	input  wire logic                      i_tx_valid,
	input  wire iacarh_pkg::iacarh_tx_type i_tx,
	output logic                           o_tx_ready,
	output var  iacarh_pkg::iacarh_tx_type o_last,
	output logic [7:0]                     o_count
);
	import iacarh_pkg::*;
	// takes messages with random stalls; the allegiance bit is never read
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_tx_ready <= 1'b0;
			o_count    <= 8'h00;
		end else begin
			o_tx_ready <= ($urandom % 4) != 0;
			if (i_tx_valid && o_tx_ready) begin
				o_last  <= i_tx;
				o_count <= o_count + 8'h01;
			end
		end
	end
endmodule : iacarh_target_model
`default_nettype wire

//--- iacarh_handler_bench.sv
`timescale 1ns/1ps
`default_nettype none
module iacarh_handler_bench;
	import iacarh_pkg::*;
	logic           i_clk_sys, i_reset, i_link_reset, i_hard_reset, i_local_reset;
	logic           i_cmd_valid, o_cmd_ready, o_tx_valid, i_tx_ready, i_rx_valid;
	logic           o_rx_ready, o_ack_valid, o_requeue_valid, o_queue_hold;
	logic           o_proto_err, o_restore_saved, i_reg_wr, i_reg_rd;
	logic [15:0]    o_requeue_tag;
	logic [7:0]     i_reg_addr, tx_count, code, lun, c0;
	logic [31:0]    i_reg_wdata, o_reg_rdata, path_val, rd;
	iacarh_cmd_type i_cmd, c;
	iacarh_tx_type  o_tx, last_tx;
	iacarh_rx_type  i_rx, r;
	iacarh_ack_type o_ack;
	int             bad_count, samples_checked, n;
	logic [7:0]     codes [5] = '{8'h00, 8'h01, 8'h04, 8'h20, 8'hff};

	iacarh_handler dut_u (.i_clk_sys, .i_reset, .i_link_reset, .i_hard_reset,
		.i_local_reset, .i_cmd_valid, .i_cmd, .o_cmd_ready, .o_tx_valid, .o_tx,
		.i_tx_ready, .i_rx_valid, .i_rx, .o_rx_ready, .o_ack_valid, .o_ack,
		.o_requeue_valid, .o_requeue_tag, .o_queue_hold, .o_proto_err,
		.o_restore_saved, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
		.o_reg_rdata);
	iacarh_target_model tgt_u (.i_clk_sys, .i_reset, .i_tx_valid(o_tx_valid),
		.i_tx(o_tx), .o_tx_ready(i_tx_ready), .o_last(last_tx), .o_count(tx_count));

	// expected decode flags: ok, not found, overlap, no allegiance, invalid, reserved
	function automatic logic [5:0] exp_flags(input logic [7:0] v);
		exp_flags = {v == 8'h00, v == 8'h01, v == 8'h04, v == 8'h20, v == 8'hff, 1'b0};
		exp_flags[0] = (exp_flags[5:1] == 5'h00);
	endfunction : exp_flags

	// acknowledgement frame as the target builds it, tag copied from the request
	function automatic iacarh_rx_type mk_ack(input logic [15:0] t, input logic [7:0] v);
		mk_ack = '0;
		mk_ack.tag = t;
		mk_ack.ack_bytes = {v, t[7:0], t[15:8], SUB_ACK, MSG_CODE};
	endfunction : mk_ack

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// hold a command or a message until the block takes it
	task automatic drive(input bit is_cmd);
		@(posedge i_clk_sys);
		i_cmd <= c;
		i_rx <= r;
		if (is_cmd) i_cmd_valid <= 1'b1;
		else i_rx_valid <= 1'b1;
		n = 0;
		do begin
			@(negedge i_clk_sys);
			n++;
		end while ((is_cmd ? o_cmd_ready : o_rx_ready) !== 1'b1 && n < 200);
		@(posedge i_clk_sys);
		i_cmd_valid <= 1'b0;
		i_rx_valid <= 1'b0;
		// look at the one-cycle answers once they have settled
		@(negedge i_clk_sys);
		check(n < 200, 1);
	endtask : drive

	task automatic wait_tx();
		n = 0;
		while (tx_count === c0 && n < 200) begin
			@(negedge i_clk_sys);
			n++;
		end
		check(n < 200, 1);
	endtask : wait_tx

	task automatic wait_hold(input logic v);
		n = 0;
		while (o_queue_hold !== v && n < 20) begin
			@(negedge i_clk_sys);
			n++;
		end
		check(o_queue_hold, v);
	endtask : wait_hold

	task automatic reg_op(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg_wr <= wr;
		i_reg_rd <= !wr;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		@(negedge i_clk_sys);
		rd = o_reg_rdata;
	endtask : reg_op

	// one cycle notice on a reset input
	task automatic pulse(input int k);
		@(posedge i_clk_sys);
		{i_link_reset, i_hard_reset, i_local_reset} <= 3'b100 >> k;
		@(posedge i_clk_sys);
		{i_link_reset, i_hard_reset, i_local_reset} <= 3'b000;
		@(negedge i_clk_sys);
	endtask : pulse

	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end

	// watchdog well past the expected run length
	initial begin
		#2_000_000;
		bad_count++;
		end_sim();
	end

	initial begin
		void'($urandom(32'h463e));
		{i_link_reset, i_hard_reset, i_local_reset, i_cmd_valid} = 4'h0;
		{i_rx_valid, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
		i_cmd = '0;
		i_rx = '0;
		i_reset = 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		@(negedge i_clk_sys);
		check({o_queue_hold, o_proto_err}, 0);
		path_val = $urandom;
		reg_op(1, REG_PATH, path_val);
		reg_op(0, REG_PATH, 0);
		check(rd, path_val);
		reg_op(0, 8'h10, 0);
		check(rd, 0);
		// every return code, then a reserved one
		for (int i = 0; i < 6; i++) begin
			code = (i < 5) ? codes[i] : 8'h21 + 8'($urandom % 200);
			lun = 8'($urandom);
			c = '{16'h0000, {$urandom, $urandom}, lun, Q_UNTAGGED, 1'b1, 1'($urandom)};
			c0 = tx_count;
			drive(1);
			wait_tx();
			check({last_tx.tag, last_tx.queue_type_field}, {8'hff, lun, Q_SIMPLE});
			check(last_tx.confirm, c.confirm);
			r = mk_ack({8'hff, lun}, code);
			drive(0);
			check({o_ack_valid, o_ack[29:0]}, {1'b1, 8'hff, lun, code, exp_flags(code)});
			@(negedge i_clk_sys);
			check(o_proto_err, i == 5);
		end
		reg_op(1, REG_STATUS, 32'h0000_0002);
		r = mk_ack({8'hff, lun}, RC_OK);
		drive(0);
		@(negedge i_clk_sys);
		check(o_proto_err, 0);
		// wrong subcode in the header: flagged, nothing decoded
		r.ack_bytes[1] = SUB_CLEAR;
		drive(0);
		check({o_ack_valid, o_proto_err}, 2'b01);
		// check condition builds an entry and holds the queue
		lun = 8'($urandom);
		c = '{16'h0011, {$urandom, $urandom}, lun, Q_SIMPLE, 1'b0, 1'b0};
		c0 = tx_count;
		drive(1);
		wait_tx();
		r = '{1'b1, 16'h0011, STAT_CHECK, 40'h0};
		drive(0);
		wait_hold(1);
		reg_op(0, REG_STATUS, 0);
		check(rd[ST_HOLD_BIT], 1);
		pulse(0);
		repeat (4) @(negedge i_clk_sys);
		check(o_queue_hold, 1);
		@(posedge i_clk_sys);
		i_cmd <= '{16'h0015, ~c.dest_id, lun, Q_SIMPLE, 1'b0, 1'b0};
		@(negedge i_clk_sys);
		check(o_cmd_ready, 0);
		c.tag = 16'h0012;
		c0 = tx_count;
		drive(1);
		wait_tx();
		check({last_tx.is_clear, last_tx.queue_type_field}, {1'b0, Q_ACA});
		r = '{1'b1, 16'h0012, 8'h00, 40'h0};
		c0 = tx_count;
		drive(0);
		wait_tx();
		check({last_tx.is_clear, last_tx.tag, last_tx.lun, last_tx.reply_path_id},
			{1'b1, CLEAR_TAG, lun, path_val});
		r = mk_ack(CLEAR_TAG, RC_OK);
		drive(0);
		wait_hold(0);
		// allegiance-active status puts the command back
		c.tag = 16'h0014;
		c0 = tx_count;
		drive(1);
		wait_tx();
		r = '{1'b1, 16'h0014, STAT_ACA_ACTIVE, 40'h0};
		drive(0);
		n = 0;
		while (o_requeue_valid !== 1'b1 && n < 20) begin
			@(negedge i_clk_sys);
			n++;
		end
		check({o_requeue_valid, o_requeue_tag}, {1'b1, 16'h0014});
		// hard reset empties a held entry, local reset restores saved state
		c.tag = 16'h0013;
		c0 = tx_count;
		drive(1);
		wait_tx();
		r = '{1'b1, 16'h0013, STAT_CHECK, 40'h0};
		drive(0);
		wait_hold(1);
		pulse(1);
		wait_hold(0);
		pulse(2);
		check(o_restore_saved, 1);
		end_sim();
	end
endmodule : iacarh_handler_bench
`default_nettype wire
